// >>> hw/flash_prot_pkg.sv
/*
  Shared constants and carriers for the flash configuration and protection
  register block. Assumes a byte-wide register set on a 32-bit Wishbone bus.
*/
package flash_prot_pkg;

  localparam logic [7:0] CFG_OFFSET        = 8'h00;
  localparam logic [7:0] PROT_OFFSET       = 8'h04;
  localparam logic [7:0] SEC_OFFSET        = 8'h08;
  localparam logic [7:0] FLAGS_OFFSET      = 8'h0c;

  localparam int CFG_BUF_EMPTY_IE_BIT      = 7;
  localparam int CFG_CMD_DONE_IE_BIT       = 6;
  localparam int CFG_KEY_ACCESS_BIT        = 5;
  localparam logic [7:0] CFG_RW_MASK       = 8'he0;
  localparam logic [7:0] CFG_RESET         = 8'h00;

  localparam int PROT_POLARITY_BIT         = 7;
  localparam int PROT_NV6_BIT              = 6;
  localparam int PROT_HIGH_DISABLE_BIT     = 5;
  localparam int PROT_HIGH_SIZE_LSB        = 3;
  localparam int PROT_LOW_DISABLE_BIT      = 2;
  localparam int PROT_LOW_SIZE_LSB         = 0;
  localparam logic [7:0] PROT_RESET        = 8'hff;

  localparam logic [1:0] KEY_ENABLED       = 2'h2;
  localparam logic [15:0] PROT_NV_ADDR     = 16'hff0d;

  localparam logic [15:0] HIGH_RANGE_END   = 16'hffff;
  localparam logic [15:0] LOW_RANGE_START  = 16'h4000;
  localparam logic [15:0] HIGH_BASE_2K     = 16'hf800;
  localparam logic [15:0] HIGH_BASE_4K     = 16'hf000;
  localparam logic [15:0] HIGH_BASE_8K     = 16'he000;
  localparam logic [15:0] HIGH_BASE_16K    = 16'hc000;
  localparam logic [15:0] LOW_LAST_1K      = 16'h43ff;
  localparam logic [15:0] LOW_LAST_2K      = 16'h47ff;
  localparam logic [15:0] LOW_LAST_4K      = 16'h4fff;
  localparam logic [15:0] LOW_LAST_8K      = 16'h5fff;

  typedef struct packed {
    logic        polarity;
    logic        nv6;
    logic        high_disable;
    logic [1:0]  high_size;
    logic        low_disable;
    logic [1:0]  low_size;
  } prot_reg_t;

  typedef struct packed {
    logic        valid;
    logic        is_mass;
    logic [15:0] addr;
  } alter_req_t;

  typedef enum logic [1:0] {
    ST_LOAD_REQ  = 2'b00,
    ST_LOAD_WAIT = 2'b01,
    ST_RUN       = 2'b10
  } boot_state_t;

endpackage

// >>> hw/flash_range_check.sv
/*
  Decides whether one array address lies in protected space for a given
  protection byte. Purely combinational; assumes 16-bit array addresses.
*/
module flash_range_check
  import flash_prot_pkg::*;
(
  input  wire flash_prot_pkg::prot_reg_t prot_i,
  input  wire logic [15:0]               addr_i,
  output logic                           protected_o,
  output logic                           fully_open_o
);

  logic [15:0] high_base;
  logic [15:0] low_last;
  logic        in_high;
  logic        in_low;
  logic        sel_high;
  logic        sel_low;

  always_comb
  begin
    // RQ20 high extent
    case (prot_i.high_size)
      2'h0:    high_base = HIGH_BASE_2K;
      2'h1:    high_base = HIGH_BASE_4K;
      2'h2:    high_base = HIGH_BASE_8K;
      default: high_base = HIGH_BASE_16K;
    endcase
    // RQ21 low extent
    case (prot_i.low_size)
      2'h0:    low_last = LOW_LAST_1K;
      2'h1:    low_last = LOW_LAST_2K;
      2'h2:    low_last = LOW_LAST_4K;
      default: low_last = LOW_LAST_8K;
    endcase
    in_high = (addr_i >= high_base) && (addr_i <= HIGH_RANGE_END);
    in_low  = (addr_i >= LOW_RANGE_START) && (addr_i <= low_last);
    // RQ16 RQ17 disable bits gate ranges
    sel_high = !prot_i.high_disable && in_high;
    sel_low  = !prot_i.low_disable && in_low;
    // RQ15 polarity swaps meaning
    if (prot_i.polarity)
      protected_o = sel_high || sel_low;
    else
      protected_o = !(sel_high || sel_low);
    // RQ14 mass erase gate
    fully_open_o = prot_i.polarity && prot_i.high_disable && prot_i.low_disable;
  end

endmodule

// >>> hw/flash_config_protection_regs.sv
/*
  Configuration and protection registers of an embedded flash module, with
  protection checking of program/erase attempts from the command logic.
  Assumes a classic Wishbone master, a flash array read port for the reset
  load, and security/status logic outside that supplies key enable and flags.
*/
// Function
// RQ1 - Config keeps only bits seven, six, five
// RQ2 - Key bit writable only when key enabled
// RQ3 - Key enable means pattern 10 only
// RQ4 - Buffer empty interrupt follows flag and enable
// RQ5 - Command done interrupt follows flag and enable
// RQ6 - Key bit steers array writes and reads
// RQ7 - Protection register readable in all modes
// RQ8 - Polarity bit only clears on write
// RQ9 - Low size writable while low disable set
// RQ10 - High size writable while high disable set
// RQ11 - Protection loaded from array at reset
// RQ12 - Software unprotects top sector before reprogramming
// RQ13 - Protected program or erase sets violation
// RQ14 - Mass erase needs all three open bits
// RQ15 - Polarity selects protected or unprotected ranges
// RQ16 - Bit five controls high range
// RQ17 - Bit two controls low range
// RQ18 - Bits four-three hold high size
// RQ19 - Bits one-zero hold low size
// RQ20 - High sizes end at top address
// RQ21 - Low sizes start at 0x4000
// RQ22 - Writes removing protection are ignored
// RQ23 - Software keeps bit six erased
// RQ24 - Interrupt request is a held level
module flash_config_protection_regs
  import flash_prot_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic [1:0]                 backdoor_key_enable_i,
  input  wire logic                       buffer_empty_flag_i,
  input  wire logic                       command_done_flag_i,
  input  wire logic                       special_mode_i,
  output logic                            nv_rd_req_o,
  output logic [15:0]                     nv_rd_addr_o,
  input  wire logic                       nv_rd_valid_i,
  input  wire logic [7:0]                 nv_rd_data_i,
  input  wire flash_prot_pkg::alter_req_t alter_req_i,
  input  wire logic                       array_write_i,
  output logic                            alter_allowed_o,
  output logic                            protect_violation_flag_o,
  output logic                            key_access_o,
  output logic                            array_write_is_key_o,
  output logic                            array_write_is_cmd_o,
  output logic                            array_read_invalid_o,
  output logic                            buffer_empty_irq_o,
  output logic                            command_done_irq_o
);

  prot_reg_t   prot;
  prot_reg_t   next_prot;
  logic [7:0]  cfg;
  logic [7:0]  next_cfg;
  boot_state_t state;
  boot_state_t next_state;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        viol;
  logic        next_viol;
  logic        allowed;
  logic        next_allowed;
  logic        irq_be;
  logic        next_irq_be;
  logic        irq_cd;
  logic        next_irq_cd;
  logic        key_w;
  logic        next_key_w;
  logic        cmd_w;
  logic        next_cmd_w;
  logic        rd_inv;
  logic        next_rd_inv;
  logic        nv_req;
  logic        next_nv_req;
  logic        hit_prot;
  logic        fully_open;
  logic        bus_req;
  logic        bus_wr;
  prot_reg_t   wr_val;
  prot_reg_t   cand;

  // Protection scenario number 0..7 from polarity and disable bits
  function automatic logic [2:0] scenario(input prot_reg_t p);
    logic [2:0] s;
    s = 3'h0;
    if (p.polarity)
      s = {1'b0, !p.high_disable, !p.low_disable};
    else if (p.high_disable && p.low_disable)
      s = 3'h4;
    else if (!p.high_disable && p.low_disable)
      s = 3'h5;
    else if (p.high_disable && !p.low_disable)
      s = 3'h6;
    else
      s = 3'h7;
    return s;
  endfunction

  // Scenario transitions that keep or add protection
  function automatic logic trans_ok(input logic [2:0] from, input logic [2:0] to);
    logic [7:0] row;
    case (from)
      3'h0:    row = 8'h0f;
      3'h1:    row = 8'h0a;
      3'h2:    row = 8'h0c;
      3'h3:    row = 8'h08;
      3'h4:    row = 8'h18;
      3'h5:    row = 8'h3c;
      3'h6:    row = 8'h5a;
      default: row = 8'hff;
    endcase
    return row[to];
  endfunction

  // Range size may change only with unchanged extent or a wider region
  function automatic logic size_ok(input logic pol, input logic dis,
                                   input logic [1:0] from, input logic [1:0] to);
    logic ok;
    ok = 1'b1;
    if (!dis && (to != from))
      ok = pol ? (to > from) : (to < from);
    return ok;
  endfunction

  flash_range_check u_range
  (
    .prot_i       (prot),
    .addr_i       (alter_req_i.addr),
    .protected_o  (hit_prot),
    .fully_open_o (fully_open)
  );

  assign bus_req = wb_cyc_i && wb_stb_i && !ack;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

  always_comb
  begin
    next_state  = state;
    next_prot   = prot;
    next_cfg    = cfg;
    next_ack    = 1'b0;
    next_rdata  = 32'h0000_0000;
    next_nv_req = 1'b0;
    wr_val      = prot_reg_t'(wb_dat_i[7:0]);
    cand        = prot;
    case (state)
      ST_LOAD_REQ:
      begin
        next_nv_req = 1'b1;
        next_state  = ST_LOAD_WAIT;
      end
      ST_LOAD_WAIT:
      begin
        next_nv_req = 1'b1;
        // RQ11 reset load from array
        if (nv_rd_valid_i)
        begin
          next_prot   = prot_reg_t'(nv_rd_data_i);
          next_nv_req = 1'b0;
          next_state  = ST_RUN;
        end
      end
      ST_RUN:
      begin
        next_ack = bus_req;
        if (bus_req && !wb_we_i)
        begin
          case (wb_adr_i)
            CFG_OFFSET:   next_rdata = {24'h000000, cfg};
            // RQ7 readable in any mode
            PROT_OFFSET:  next_rdata = {24'h000000, prot};
            SEC_OFFSET:   next_rdata = {30'h0, backdoor_key_enable_i};
            FLAGS_OFFSET: next_rdata = {28'h0, special_mode_i, viol,
                                        command_done_flag_i, buffer_empty_flag_i};
            default:      next_rdata = 32'h0000_0000;
          endcase
        end
        if (bus_wr && (wb_adr_i == CFG_OFFSET))
        begin
          // RQ1 only three bits stored
          next_cfg = wb_dat_i[7:0] & CFG_RW_MASK;
          // RQ2 RQ3 key bit gated
          if (backdoor_key_enable_i != KEY_ENABLED)
            next_cfg[CFG_KEY_ACCESS_BIT] = cfg[CFG_KEY_ACCESS_BIT];
        end
        if (bus_wr && (wb_adr_i == PROT_OFFSET))
        begin
          // RQ8 polarity only clears
          cand.polarity     = prot.polarity & wr_val.polarity;
          cand.high_disable = wr_val.high_disable;
          cand.low_disable  = wr_val.low_disable;
          // RQ18 RQ10 high size while disabled
          if (prot.high_disable)
            cand.high_size = wr_val.high_size;
          // RQ19 RQ9 low size while disabled
          if (prot.low_disable)
            cand.low_size = wr_val.low_size;
          // RQ22 drop writes that remove protection
          if (trans_ok(scenario(prot), scenario(cand))
              && size_ok(cand.polarity, cand.high_disable, prot.high_size, cand.high_size)
              && size_ok(cand.polarity, cand.low_disable, prot.low_size, cand.low_size))
            next_prot = cand;
        end
      end
      default:
      begin
        next_state = ST_LOAD_REQ;
      end
    endcase
  end

  always_comb
  begin
    next_viol    = viol;
    next_allowed = 1'b0;
    // Software clears by writing one to bit 2 of the flags word; set wins
    if (bus_wr && (wb_adr_i == FLAGS_OFFSET) && wb_dat_i[2])
      next_viol = 1'b0;
    if (alter_req_i.valid && (state == ST_RUN))
    begin
      // RQ14 mass erase refusal
      if (alter_req_i.is_mass ? !fully_open : hit_prot)
        // RQ13 violation flag set
        next_viol = 1'b1;
      else
        next_allowed = 1'b1;
    end
    // RQ4 RQ24 buffer empty level
    next_irq_be = buffer_empty_flag_i && next_cfg[CFG_BUF_EMPTY_IE_BIT];
    // RQ5 RQ24 command done level
    next_irq_cd = command_done_flag_i && next_cfg[CFG_CMD_DONE_IE_BIT];
    // RQ6 key bit steers array access
    next_key_w  = array_write_i && cfg[CFG_KEY_ACCESS_BIT];
    next_cmd_w  = array_write_i && !cfg[CFG_KEY_ACCESS_BIT];
    next_rd_inv = next_cfg[CFG_KEY_ACCESS_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state   <= ST_LOAD_REQ;
      prot    <= prot_reg_t'(PROT_RESET);
      cfg     <= CFG_RESET;
      ack     <= 1'b0;
      rdata   <= 32'h0000_0000;
      nv_req  <= 1'b0;
      viol    <= 1'b0;
      allowed <= 1'b0;
      irq_be  <= 1'b0;
      irq_cd  <= 1'b0;
      key_w   <= 1'b0;
      cmd_w   <= 1'b0;
      rd_inv  <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      prot    <= next_prot;
      cfg     <= next_cfg;
      ack     <= next_ack;
      rdata   <= next_rdata;
      nv_req  <= next_nv_req;
      viol    <= next_viol;
      allowed <= next_allowed;
      irq_be  <= next_irq_be;
      irq_cd  <= next_irq_cd;
      key_w   <= next_key_w;
      cmd_w   <= next_cmd_w;
      rd_inv  <= next_rd_inv;
    end
  end

  assign wb_dat_o                 = rdata;
  assign wb_ack_o                 = ack;
  assign nv_rd_req_o              = nv_req;
  assign nv_rd_addr_o             = PROT_NV_ADDR;
  assign alter_allowed_o          = allowed;
  assign protect_violation_flag_o = viol;
  assign key_access_o             = cfg[CFG_KEY_ACCESS_BIT];
  assign array_write_is_key_o     = key_w;
  assign array_write_is_cmd_o     = cmd_w;
  assign array_read_invalid_o     = rd_inv;
  assign buffer_empty_irq_o       = irq_be;
  assign command_done_irq_o       = irq_cd;

endmodule

// >>> verif/nv_array_model.sv
/* Array read port model for the reset load of the protection byte.
   Assumes a request level held until the byte is handed over. */
module nv_array_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  byte_i,
  output logic             valid_o,
  output logic [7:0]       data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  always @(posedge clk_i)
  begin
    valid_o <= 1'b0;
    // Idle data toggles so a stale byte is never mistaken for an answer
    data_o <= ~data_o;
    wait_cnt <= (!req_i || valid_o) ? 2'd0 : wait_cnt + 2'd1;
    if (req_i && wait_cnt == 2'd3 && !valid_o)
    begin
      valid_o <= 1'b1;
      data_o <= (addr_i == 16'hff0d) ? (byte_i | 8'h40) : ~byte_i;
    end
    if (rst_i)
    begin
      valid_o <= 1'b0;
      data_o <= 8'h5a;
      wait_cnt <= 2'd0;
    end
  end
endmodule

// >>> verif/flash_prot_sva.sv
/* Port assertions for the flash protection register block.
   Assumes it is bound to flash_config_protection_regs. */
module flash_prot_sva
  import flash_prot_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_ack_o,
  input wire logic [1:0]                 backdoor_key_enable_i,
  input wire logic                       buffer_empty_flag_i,
  input wire logic                       command_done_flag_i,
  input wire logic                       nv_rd_req_o,
  input wire logic                       nv_rd_valid_i,
  input wire flash_prot_pkg::alter_req_t alter_req_i,
  input wire logic                       array_write_i,
  input wire logic                       protect_violation_flag_o,
  input wire logic                       key_access_o,
  input wire logic                       array_write_is_key_o,
  input wire logic                       array_write_is_cmd_o,
  input wire logic                       buffer_empty_irq_o,
  input wire logic                       command_done_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  key_gate_a:
    assert property ($rose(key_access_o) |-> $past(backdoor_key_enable_i) == KEY_ENABLED)
    else $error("key bit set while key disabled");
  empty_irq_a:
    assert property (buffer_empty_irq_o |-> $past(buffer_empty_flag_i))
    else $error("buffer empty irq without flag");
  done_irq_a:
    assert property (command_done_irq_o |-> $past(command_done_flag_i))
    else $error("command done irq without flag");
  key_route_a:
    assert property (array_write_is_key_o |-> $past(array_write_i && key_access_o))
    else $error("key write misrouted");
  cmd_route_a:
    assert property (array_write_is_cmd_o |-> $past(array_write_i && !key_access_o))
    else $error("command write misrouted");
  viol_cause_a:
    assert property ($rose(protect_violation_flag_o) |-> $past(alter_req_i.valid))
    else $error("violation without attempt");
  load_done_a:
    assert property ($fell(nv_rd_req_o) |-> $past(nv_rd_valid_i))
    else $error("load ended without byte");
endmodule
bind flash_config_protection_regs flash_prot_sva u_sva (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .backdoor_key_enable_i, .buffer_empty_flag_i, .command_done_flag_i,
  .nv_rd_req_o, .nv_rd_valid_i, .alter_req_i, .array_write_i, .protect_violation_flag_o,
  .key_access_o, .array_write_is_key_o, .array_write_is_cmd_o, .buffer_empty_irq_o,
  .command_done_irq_o);

// >>> verif/flash_config_protection_regs_test.sv
/* Self-checking bench for the flash protection register block.
   Assumes the array model answers the reset load of the protection byte. */
module flash_config_protection_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_prot_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, nv_rd_data_i, boot_byte = 8'hff;
  logic [3:0]  wb_sel_i = 4'hf, e;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, nv_rd_req_o, nv_rd_valid_i, alter_allowed_o, special_mode_i = 1'b0;
  logic [1:0]  backdoor_key_enable_i = 2'h0;
  logic        buffer_empty_flag_i = 1'b0, command_done_flag_i = 1'b0, array_write_i = 1'b0;
  logic [15:0] nv_rd_addr_o;
  alter_req_t  alter_req_i = '0;
  logic        protect_violation_flag_o, key_access_o, array_write_is_key_o;
  logic        array_write_is_cmd_o, array_read_invalid_o, buffer_empty_irq_o;
  logic        command_done_irq_o;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;

  flash_config_protection_regs u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .backdoor_key_enable_i,
    .buffer_empty_flag_i, .command_done_flag_i, .special_mode_i, .nv_rd_req_o, .nv_rd_addr_o,
    .nv_rd_valid_i, .nv_rd_data_i, .alter_req_i, .array_write_i, .alter_allowed_o,
    .protect_violation_flag_o, .key_access_o, .array_write_is_key_o, .array_write_is_cmd_o,
    .array_read_invalid_o, .buffer_empty_irq_o, .command_done_irq_o);
  nv_array_model u_nv (.clk_i, .rst_i, .req_i(nv_rd_req_o), .addr_i(nv_rd_addr_o),
    .byte_i(boot_byte), .valid_o(nv_rd_valid_i), .data_o(nv_rd_data_i));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] exp_cfg(input logic [7:0] d, input logic [1:0] k);
    return {24'h0, d & CFG_RW_MASK & ((k == KEY_ENABLED) ? 8'hff : 8'hdf)};
  endfunction

  // One classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic boot(input logic [7:0] b);
    boot_byte = b;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    while (nv_rd_req_o !== 1'b1)
      @(posedge clk_i);
    while (nv_rd_req_o !== 1'b0)
      @(posedge clk_i);
  endtask

  task automatic alter(input logic m, input logic [15:0] a, input logic ok);
    alter_req_i <= '{1'b1, m, a};
    @(posedge clk_i);
    alter_req_i <= '0;
    @(posedge clk_i);
    chk("alter allowed", alter_allowed_o, ok);
  endtask

  initial
  begin
    void'($urandom(57949));
    boot(8'h7f);
    special_mode_i <= 1'b1;
    wb(1'b0, PROT_OFFSET, 8'h00);
    chk("prot load", q, 32'h7f);
    wb(1'b1, PROT_OFFSET, 8'hff);
    wb(1'b0, PROT_OFFSET, 8'h00);
    chk("prot polarity", q, 32'h7f);
    alter(1'b0, 16'h8000, 1'b0);
    chk("violation", protect_violation_flag_o, 1'b1);
    wb(1'b0, FLAGS_OFFSET, 8'h00);
    chk("flags", q, 32'h0c);
    wb(1'b1, FLAGS_OFFSET, 8'h04);
    chk("violation clear", protect_violation_flag_o, 1'b0);
    alter(1'b1, 16'h0000, 1'b0);
    special_mode_i <= 1'b0;
    boot(8'hff);
    alter(1'b1, 16'h0000, 1'b1);
    // Upper sector open, so the protection byte may be programmed
    alter(1'b0, PROT_NV_ADDR, 1'b1);
    wb(1'b1, PROT_OFFSET, 8'hdb);
    wb(1'b0, PROT_OFFSET, 8'h00);
    chk("prot add", q, 32'hdb);
    wb(1'b1, PROT_OFFSET, 8'hc0);
    wb(1'b0, PROT_OFFSET, 8'h00);
    chk("prot frozen", q, 32'hdb);
    wb(1'b1, PROT_OFFSET, 8'hdf);
    wb(1'b0, PROT_OFFSET, 8'h00);
    chk("prot keep", q, 32'hdb);
    alter(1'b0, 16'hc000, 1'b0);
    alter(1'b0, 16'hbfff, 1'b1);
    alter(1'b0, 16'h5fff, 1'b0);
    alter(1'b0, 16'h6000, 1'b1);
    wb(1'b0, 8'h10, 8'h00);
    chk("unmapped", q, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      backdoor_key_enable_i <= k[1:0];
      wb(1'b1, CFG_OFFSET, 8'hff);
      wb(1'b0, CFG_OFFSET, 8'h00);
      chk("cfg", q, exp_cfg(8'hff, k[1:0]));
      chk("key bit", key_access_o, k == 2);
      array_write_i <= 1'b1;
      @(posedge clk_i);
      array_write_i <= 1'b0;
      @(posedge clk_i);
      chk("key route", array_write_is_key_o, k == 2);
      chk("cmd route", array_write_is_cmd_o, k != 2);
      chk("read invalid", array_read_invalid_o, k == 2);
      wb(1'b1, CFG_OFFSET, 8'h00);
    end
    repeat (16)
    begin
      e = 4'($urandom);
      wb(1'b1, CFG_OFFSET, {e[1:0], 6'h0});
      buffer_empty_flag_i <= e[2];
      command_done_flag_i <= e[3];
      repeat (2) @(posedge clk_i);
      chk("empty irq", buffer_empty_irq_o, e[1] & e[2]);
      chk("done irq", command_done_irq_o, e[0] & e[3]);
    end
    close_out();
  end
endmodule
